// file: hw/ufc_defines.svh
`ifndef UFC_DEFINES_SVH
`define UFC_DEFINES_SVH

// register indices on the plain port
`define UFC_ADDR_CTRL1      3'h0
`define UFC_ADDR_CTRL2      3'h1
`define UFC_ADDR_STATUS     3'h2
`define UFC_ADDR_DATA       3'h3
`define UFC_ADDR_DIVISOR    3'h4
`define UFC_ADDR_IRQ_STAT   3'h5
`define UFC_ADDR_IRQ_CLR    3'h6
`define UFC_ADDR_IRQ_EN     3'h7

// frame control field positions
`define UFC_F_ENABLE        7
`define UFC_F_NINE          6
`define UFC_F_PAR_EN        5
`define UFC_F_PAR_ODD       4
`define UFC_F_STOP2         3
`define UFC_F_BREAK         2
`define UFC_F_RX9           1
`define UFC_F_TX9           0

// control two field positions
`define UFC_F_TX_EN         7
`define UFC_F_RX_EN         6

// reset values
`define UFC_RST_CTRL        8'h00
`define UFC_RST_DIV         8'h00

// timing
`define UFC_OVERSAMPLE      4'hf
`define UFC_BREAK_BITS      5'h0d

`endif

// file: hw/ufc_pkg.sv
package ufc_pkg;

    // register port request
    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } ufc_req_t;

    // status flags, in status register order
    typedef struct packed {
        logic par_err;
        logic noise;
        logic frm_err;
        logic overrun;
        logic rx_idle;
        logic rx_avail;
        logic tx_idle;
        logic tx_empty;
    } ufc_stat_t;

    typedef enum logic [2:0] {
        UFC_TX_IDLE,
        UFC_TX_START,
        UFC_TX_DATA,
        UFC_TX_STOP,
        UFC_TX_BREAK
    } ufc_tx_st_t;

    typedef enum logic [1:0] {
        UFC_RX_IDLE,
        UFC_RX_START,
        UFC_RX_DATA,
        UFC_RX_STOP
    } ufc_rx_st_t;

endpackage

// file: hw/ufc_uart.sv
// Contract
// [R1] With the enable bit at 0 the whole port is off and both pins float.
// [R2] With the enable bit at 1 the pins work per transmitter/receiver enable.
// [R3] Disabling empties the buffer, drops held characters, resets baud count.
// [R4] Disabling clears enables, break and error flags; sets the idle flags.
// [R5] Disabling keeps other control bits and the divisor unchanged.
// [R6] Disabling mid-transfer aborts all transfers at once, then resets.
// [R7] Length select picks 8-bit characters at 0 and 9-bit at 1.
// [R8] In 9-bit form the ninth bits come from and go to the control register.
// [R9] Parity enable replaces the top data bit with a parity bit.
// [R10] Parity type selects odd at 1 and even at 0.
// [R11] Stop select gives two stop bits at 1 and one at 0.
// [R12] Break holds the line low for at least 13 bit times until cleared.
// [R13] Receive ninth bit read-only, transmit ninth bit write-only, rest 0.
// [R14] The transmit pin is driven only when both enables are 1.
// [R15] Parity makes the count of ones even or odd as selected.
// [R16] Each character has one low start bit and goes LSB first.
`timescale 1ns/100ps
`include "ufc_defines.svh"

module ufc_uart (
    // clock and reset
    input  wire logic            ref_clk_in,
    input  wire logic            sys_rst_in,
    // register port
    input  wire ufc_pkg::ufc_req_t req_in,
    output logic [7:0]           rdata_out,
    // serial pins
    output logic                 tx_o_out,
    output logic                 tx_oe_out,
    input  wire logic            rx_i_in,
    output logic                 rx_ie_out,
    // interrupt
    output logic                 irq_out
);

    // control state
    logic [7:0] ctrl1_ff;
    logic [7:0] ctrl2_ff;
    logic [7:0] div_ff;
    logic [7:0] rdata_ff;
    logic [7:0] irq_st_ff;
    logic [7:0] irq_en_ff;
    ufc_pkg::ufc_stat_t stat_ff;
    logic [7:0] rx_data_ff;
    logic [7:0] tx_hold_ff;
    logic       tx_hold9_ff;

    // baud tick and decode
    logic [7:0] baud_cnt_ff;
    logic [3:0] ovs_tx_ff;
    logic [3:0] ovs_rx_ff;
    wire en       = ctrl1_ff[`UFC_F_ENABLE];
    wire tx_en    = en & ctrl2_ff[`UFC_F_TX_EN];
    wire rx_en    = en & ctrl2_ff[`UFC_F_RX_EN];
    wire nine     = ctrl1_ff[`UFC_F_NINE];
    wire par_en   = ctrl1_ff[`UFC_F_PAR_EN];
    wire par_odd  = ctrl1_ff[`UFC_F_PAR_ODD];
    wire brk      = ctrl1_ff[`UFC_F_BREAK];
    wire tick     = en & (baud_cnt_ff == div_ff);
    wire tx_bit   = tick & (ovs_tx_ff == `UFC_OVERSAMPLE);
    wire wr_c1    = req_in.wr & (req_in.addr == `UFC_ADDR_CTRL1);
    wire wr_c2    = req_in.wr & (req_in.addr == `UFC_ADDR_CTRL2);
    wire wr_data  = req_in.wr & (req_in.addr == `UFC_ADDR_DATA);
    wire rd_data  = req_in.rd & (req_in.addr == `UFC_ADDR_DATA);
    wire disable_now = wr_c1 & en & ~req_in.wdata[`UFC_F_ENABLE];
    // data bits per character: 8 or 9 [R7]
    wire [3:0] nbits = nine ? 4'h9 : 4'h8;

    // baud counter is cleared while disabled [R3]
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in || !en || tick) begin
            baud_cnt_ff <= 8'h00;
        end else begin
            baud_cnt_ff <= baud_cnt_ff + 8'h01;
        end
    end

    // ---- transmitter ----
    ufc_pkg::ufc_tx_st_t tx_st_ff;
    logic [8:0] tx_sh_ff;
    logic [3:0] tx_idx_ff;
    logic [4:0] tx_brk_ff;
    logic       tx_stop_ff;
    logic       tx_line_ff;
    // parity over the data bits below the top position [R15] [R10]
    wire [8:0] tx_word  = {tx_hold9_ff, tx_hold_ff};
    wire [8:0] tx_lowm  = nine ? 9'h0ff : 9'h07f;
    wire       tx_par   = ^(tx_word & tx_lowm) ^ par_odd;
    wire [8:0] tx_frame = !par_en ? tx_word :
                          nine ? {tx_par, tx_word[7:0]} :
                                 {1'b0, tx_par, tx_word[6:0]}; // [R9]

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in || !tx_en) begin
            // abort the frame at once and float the pin [R6] [R14]
            tx_st_ff   <= ufc_pkg::UFC_TX_IDLE;
            tx_line_ff <= 1'b1;
            ovs_tx_ff  <= 4'h0;
            tx_idx_ff  <= 4'h0;
            tx_brk_ff  <= 5'h00;
            tx_stop_ff <= 1'b0;
            tx_sh_ff   <= 9'h000;
        end else begin
            if (tick) begin
                ovs_tx_ff <= ovs_tx_ff + 4'h1;
            end
            if (tx_bit) begin
                case (tx_st_ff)
                    // after the last stop bit the next start follows at
                    // once, so one stop bit really is one bit time [R11]
                    ufc_pkg::UFC_TX_IDLE, ufc_pkg::UFC_TX_START: begin
                        if (!stat_ff.tx_empty) begin
                            tx_sh_ff   <= tx_frame;
                            tx_line_ff <= 1'b0; // start bit [R16]
                            tx_st_ff   <= ufc_pkg::UFC_TX_DATA;
                            tx_idx_ff  <= 4'h0;
                        end else if (brk) begin
                            // break only after buffered data drained [R12]
                            tx_line_ff <= 1'b0;
                            tx_brk_ff  <= 5'h01;
                            tx_st_ff   <= ufc_pkg::UFC_TX_BREAK;
                        end else begin
                            tx_st_ff   <= ufc_pkg::UFC_TX_IDLE;
                        end
                    end
                    ufc_pkg::UFC_TX_DATA: begin
                        tx_line_ff <= tx_sh_ff[0]; // lsb first [R16]
                        tx_sh_ff   <= {1'b0, tx_sh_ff[8:1]};
                        tx_idx_ff  <= tx_idx_ff + 4'h1;
                        if (tx_idx_ff == nbits - 4'h1) begin
                            tx_st_ff   <= ufc_pkg::UFC_TX_STOP;
                            tx_stop_ff <= ctrl1_ff[`UFC_F_STOP2]; // [R11]
                        end
                    end
                    ufc_pkg::UFC_TX_STOP: begin
                        tx_line_ff <= 1'b1;
                        if (tx_stop_ff) begin
                            tx_stop_ff <= 1'b0;
                        end else begin
                            tx_st_ff <= ufc_pkg::UFC_TX_START;
                        end
                    end
                    ufc_pkg::UFC_TX_BREAK: begin
                        // hold low 13 bits minimum, then until cleared [R12]
                        if (tx_brk_ff != `UFC_BREAK_BITS) begin
                            tx_brk_ff <= tx_brk_ff + 5'h01;
                        end else if (!brk) begin
                            tx_line_ff <= 1'b1;
                            tx_st_ff   <= ufc_pkg::UFC_TX_IDLE;
                        end
                    end
                    default: tx_st_ff <= ufc_pkg::UFC_TX_IDLE;
                endcase
            end
        end
    end
    wire tx_load = tx_bit & !stat_ff.tx_empty
                   & ((tx_st_ff == ufc_pkg::UFC_TX_IDLE)
                      | (tx_st_ff == ufc_pkg::UFC_TX_START));
    wire tx_busy = (tx_st_ff != ufc_pkg::UFC_TX_IDLE) | !stat_ff.tx_empty;

    // ---- receiver ----
    ufc_pkg::ufc_rx_st_t rx_st_ff;
    logic [8:0] rx_sh_ff;
    logic [3:0] rx_idx_ff;
    logic [2:0] rx_smp_ff;
    wire rx_mid  = tick & (ovs_rx_ff == 4'h7);
    wire rx_vote = (rx_smp_ff[0] & rx_smp_ff[1]) | (rx_smp_ff[0] & rx_i_in)
                 | (rx_smp_ff[1] & rx_i_in);
    wire rx_nz   = (rx_smp_ff[1:0] != {rx_i_in, rx_i_in});
    // received word check [R15] [R10]
    wire [8:0] rx_lowm = nine ? 9'h0ff : 9'h07f;
    wire [8:0] rx_ptop = nine ? 9'h100 : 9'h080;
    wire rx_done = rx_mid & (rx_st_ff == ufc_pkg::UFC_RX_STOP);
    // 8-bit frames arrive shifted one place: realign before storing
    wire [8:0] rx_word = nine ? rx_sh_ff : {1'b0, rx_sh_ff[8:1]};
    // check the realigned word, so parity sits at bit 7 or bit 8
    wire rx_parity_error_flag = par_en & (^(rx_word & (rx_lowm | rx_ptop)) != par_odd);
    logic rx_noise_ff;

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in || !rx_en) begin
            // abort any reception in progress [R6]
            rx_st_ff    <= ufc_pkg::UFC_RX_IDLE;
            rx_sh_ff    <= 9'h000;
            rx_idx_ff   <= 4'h0;
            ovs_rx_ff   <= 4'h0;
            rx_smp_ff   <= 3'h7;
            rx_noise_ff <= 1'b0;
        end else begin
            if (tick) begin
                rx_smp_ff <= {rx_smp_ff[1:0], rx_i_in};
                ovs_rx_ff <= ovs_rx_ff + 4'h1;
            end
            case (rx_st_ff)
                ufc_pkg::UFC_RX_IDLE: begin
                    if (tick && !rx_i_in) begin
                        rx_st_ff    <= ufc_pkg::UFC_RX_START;
                        ovs_rx_ff   <= 4'h0;
                        rx_noise_ff <= 1'b0;
                    end
                end
                ufc_pkg::UFC_RX_START: begin
                    if (rx_mid) begin
                        // false start returns to idle
                        rx_st_ff  <= rx_vote ? ufc_pkg::UFC_RX_IDLE
                                             : ufc_pkg::UFC_RX_DATA;
                        rx_idx_ff <= 4'h0;
                    end
                end
                ufc_pkg::UFC_RX_DATA: begin
                    if (rx_mid) begin
                        rx_sh_ff    <= {rx_vote, rx_sh_ff[8:1]}; // [R16]
                        rx_noise_ff <= rx_noise_ff | rx_nz;
                        rx_idx_ff   <= rx_idx_ff + 4'h1;
                        if (rx_idx_ff == nbits - 4'h1) begin
                            rx_st_ff <= ufc_pkg::UFC_RX_STOP;
                        end
                    end
                end
                ufc_pkg::UFC_RX_STOP: begin
                    if (rx_mid) begin
                        rx_st_ff <= ufc_pkg::UFC_RX_IDLE;
                    end
                end
                default: rx_st_ff <= ufc_pkg::UFC_RX_IDLE;
            endcase
        end
    end

    // ---- registers and flags ----
    // writes turning the enable bit from 1 to 0 clear break and both enables; divisor kept [R4] [R5]
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            ctrl1_ff <= `UFC_RST_CTRL;
            ctrl2_ff <= `UFC_RST_CTRL;
            div_ff   <= `UFC_RST_DIV;
        end else begin
            if (wr_c1) begin
                // ninth receive bit is never written by software [R13]
                ctrl1_ff <= {req_in.wdata[7:2], ctrl1_ff[`UFC_F_RX9],
                             req_in.wdata[0]};
            end else if (rx_done && nine) begin
                ctrl1_ff[`UFC_F_RX9] <= rx_sh_ff[8]; // [R8]
            end
            if (disable_now) begin
                ctrl1_ff[`UFC_F_BREAK] <= 1'b0; // [R4]
                ctrl2_ff[`UFC_F_TX_EN] <= 1'b0;
                ctrl2_ff[`UFC_F_RX_EN] <= 1'b0;
            end else if (wr_c2) begin
                ctrl2_ff <= req_in.wdata;
            end
            if (req_in.wr && req_in.addr == `UFC_ADDR_DIVISOR) begin
                div_ff <= req_in.wdata;
            end
        end
    end

    // transmit holding buffer and receive data
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            tx_hold_ff  <= 8'h00;
            tx_hold9_ff <= 1'b0;
            rx_data_ff  <= 8'h00;
        end else begin
            if (wr_data && tx_en) begin
                tx_hold_ff  <= req_in.wdata;
                tx_hold9_ff <= ctrl1_ff[`UFC_F_TX9]; // [R8]
            end
            if (rx_done && !stat_ff.rx_avail) begin
                rx_data_ff <= rx_word[7:0];
            end
        end
    end

    // status: disable drains buffer and forces idle flags [R3] [R4]
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in || !en || disable_now) begin
            stat_ff <= 8'h0b;
        end else begin
            stat_ff.tx_empty <= (stat_ff.tx_empty & !(wr_data & tx_en))
                                | tx_load | !tx_en;
            stat_ff.tx_idle  <= !tx_busy;
            stat_ff.rx_idle  <= (rx_st_ff == ufc_pkg::UFC_RX_IDLE);
            if (rx_done && !stat_ff.rx_avail) begin
                stat_ff.rx_avail <= 1'b1;
                stat_ff.frm_err  <= !rx_vote;
                stat_ff.par_err  <= rx_parity_error_flag;
                stat_ff.noise    <= rx_noise_ff;
            end else if (rd_data) begin
                stat_ff.rx_avail <= 1'b0;
                stat_ff.frm_err  <= 1'b0;
                stat_ff.par_err  <= 1'b0;
                stat_ff.noise    <= 1'b0;
            end
            if (rx_done && stat_ff.rx_avail) begin
                stat_ff.overrun <= 1'b1;
            end else if (rd_data) begin
                stat_ff.overrun <= 1'b0;
            end
        end
    end

    // sticky interrupt bits; a new event beats a same-cycle clear
    wire [7:0] irq_ev = {stat_ff.par_err, stat_ff.noise, stat_ff.frm_err,
                         stat_ff.overrun, 2'b00, stat_ff.tx_idle,
                         stat_ff.tx_empty} & {8{en}};
    wire irq_clr = req_in.wr & (req_in.addr == `UFC_ADDR_IRQ_CLR);
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            irq_st_ff <= 8'h00;
            irq_en_ff <= 8'h00;
        end else begin
            irq_st_ff <= (irq_st_ff & ~({8{irq_clr}} & req_in.wdata))
                         | irq_ev | {5'h00, rx_done, 2'b00};
            if (req_in.wr && req_in.addr == `UFC_ADDR_IRQ_EN) begin
                irq_en_ff <= req_in.wdata;
            end
        end
    end

    // read mux; transmit ninth bit reads as zero [R13]
    logic [7:0] rd_mux;
    always_comb begin
        case (req_in.addr)
            `UFC_ADDR_CTRL1:    rd_mux = {ctrl1_ff[7:1], 1'b0};
            `UFC_ADDR_CTRL2:    rd_mux = ctrl2_ff;
            `UFC_ADDR_STATUS:   rd_mux = stat_ff;
            `UFC_ADDR_DATA:     rd_mux = rx_data_ff;
            `UFC_ADDR_DIVISOR:  rd_mux = div_ff;
            `UFC_ADDR_IRQ_STAT: rd_mux = irq_st_ff;
            `UFC_ADDR_IRQ_EN:   rd_mux = irq_en_ff;
            default:            rd_mux = 8'h00;
        endcase
    end
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= req_in.rd ? rd_mux : 8'h00;
        end
    end

    // pins float unless the port and the direction are both on [R1] [R2]
    assign tx_o_out  = tx_line_ff;
    assign tx_oe_out = tx_en; // [R14]
    assign rx_ie_out = rx_en; // [R2]
    assign rdata_out = rdata_ff;
    assign irq_out   = |(irq_st_ff & irq_en_ff);

endmodule // ufc_uart

// file: verification/ufc_uart_properties.sv
`timescale 1ns/100ps
module ufc_uart_properties (
    // clock and reset
    input  wire logic              ref_clk_in,
    input  wire logic              sys_rst_in,
    // register port
    input  wire ufc_pkg::ufc_req_t req_in,
    input  wire logic [7:0]        rdata_out,
    // serial pins and interrupt
    input  wire logic              tx_o_out,
    input  wire logic              tx_oe_out,
    input  wire logic              rx_i_in,
    input  wire logic              rx_ie_out,
    input  wire logic              irq_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (sys_rst_in);

    // steps of a disable followed at once by a status read
    sequence s_off_wr;
        req_in.wr && req_in.addr == 3'h0 && !req_in.wdata[7];
    endsequence
    sequence s_stat_rd;
        req_in.rd && req_in.addr == 3'h2;
    endsequence

    // pins and status after the enable bit drops
    a_off_pins_float: assert property (
        s_off_wr |=> !tx_oe_out && !rx_ie_out)
        else $error("pins still driven after disable");
    a_off_status_idle: assert property (
        s_off_wr ##1 s_stat_rd |=> rdata_out == 8'h0b)
        else $error("status not idle after disable");
    // read data stands only in the cycle after the strobe
    a_rdata_one_cycle: assert property (
        !$past(req_in.rd) |-> rdata_out == 8'h00)
        else $error("read data outside its cycle");
    a_clear_reads_zero: assert property (
        req_in.rd && req_in.addr == 3'h6 |=> rdata_out == 8'h00)
        else $error("irq clear register read back");
    a_irq_mask_off: assert property (
        req_in.wr && req_in.addr == 3'h7 && req_in.wdata == 8'h00
        |=> !irq_out)
        else $error("irq high with all sources masked");
    // pin drive only starts from a control write
    a_tx_oe_cause: assert property (
        $rose(tx_oe_out) |-> $past(req_in.wr)
        && $past(req_in.addr) inside {3'h0, 3'h1})
        else $error("transmit pin driven without enables");
    a_rx_ie_cause: assert property (
        $rose(rx_ie_out) |-> $past(req_in.wr)
        && $past(req_in.addr) inside {3'h0, 3'h1})
        else $error("receive pin used without enables");
    // a bit is checked to last at least 9 clocks even at the fastest divisor
    a_bit_min_len: assert property (
        tx_oe_out && $changed(tx_o_out)
        |=> (!tx_oe_out || $stable(tx_o_out)) [*8])
        else $error("transmit bit shorter than a bit time");
endmodule // ufc_uart_properties

bind ufc_uart ufc_uart_properties u_props (.ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in), .req_in(req_in), .rdata_out(rdata_out),
    .tx_o_out(tx_o_out), .tx_oe_out(tx_oe_out), .rx_i_in(rx_i_in),
    .rx_ie_out(rx_ie_out), .irq_out(irq_out));

// file: verification/ufc_remote.sv
`timescale 1ns/100ps
module ufc_remote #(
    parameter int BIT_CLKS = 16
) (
    // clock
    input  wire logic ref_clk_in,
    // line from the block
    input  wire logic tx_o_in,
    input  wire logic tx_oe_in,
    // line into the block
    output logic      rx_line_out
);
    int unsigned cyc        = 0;
    int unsigned n_frames   = 0;
    int unsigned last_start = 0;
    int unsigned prev_start = 0;
    logic [8:0]  last_raw   = 9'h000;
    logic        line;

    // a released transmit pin reads high through the line pull-up
    assign line = tx_oe_in ? tx_o_in : 1'b1;

    // free cycle count, used only for start-to-start spacing
    always @(posedge ref_clk_in) begin
        cyc <= cyc + 1;
    end

    // sample every bit at its centre; stop bit only seen in 8-bit form
    initial begin
        rx_line_out = 1'b1;
        forever begin
            @(posedge ref_clk_in);
            if (!line) begin
                prev_start = last_start;
                last_start = cyc;
                repeat (BIT_CLKS / 2) @(posedge ref_clk_in);
                for (int i = 0; i < 9; i++) begin
                    repeat (BIT_CLKS) @(posedge ref_clk_in);
                    last_raw[i] = line;
                end
                n_frames++;
                // re-arm only once the line is high again: a low ninth
                // bit must not be taken for the next start bit
                while (!line) @(posedge ref_clk_in);
            end
        end
    end

    // far end frames a character: low start, lsb first, one stop
    task automatic send(input logic [8:0] d, input int nb);
        rx_line_out <= 1'b0;
        repeat (BIT_CLKS) @(posedge ref_clk_in);
        for (int i = 0; i < nb; i++) begin
            rx_line_out <= d[i];
            repeat (BIT_CLKS) @(posedge ref_clk_in);
        end
        rx_line_out <= 1'b1;
        repeat (BIT_CLKS) @(posedge ref_clk_in);
    endtask
endmodule // ufc_remote

// file: verification/uart_frame_control_tb.sv
`timescale 1ns/100ps
module uart_frame_control_tb;
    logic              ref_clk_in;
    logic              sys_rst_in;
    ufc_pkg::ufc_req_t req_in;
    logic [7:0]        rdata_out;
    logic              tx_o_out;
    logic              tx_oe_out;
    logic              rx_i_in;
    logic              rx_ie_out;
    logic              irq_out;
    int                n_mismatch = 0;
    int                checks     = 0;
    logic [7:0]        d;

    ufc_uart u_dut (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
        .req_in(req_in), .rdata_out(rdata_out), .tx_o_out(tx_o_out),
        .tx_oe_out(tx_oe_out), .rx_i_in(rx_i_in), .rx_ie_out(rx_ie_out),
        .irq_out(irq_out));
    ufc_remote u_remote (.ref_clk_in(ref_clk_in), .tx_o_in(tx_o_out),
        .tx_oe_in(tx_oe_out), .rx_line_out(rx_i_in));

    // shared compare, bus cycles and waits
    task automatic chk(input string what, input logic [8:0] e,
                       input logic [8:0] g);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge ref_clk_in);
        req_in <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk_in);
        req_in <= '0;
        #1; // let the write land before callers look at outputs
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        @(posedge ref_clk_in);
        req_in <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk_in);
        req_in <= '0;
        #1;
        v = rdata_out;
    endtask
    task automatic rdc(input logic [2:0] a, input logic [7:0] e,
                       input string what);
        rd(a, d);
        chk(what, {1'b0, e}, {1'b0, d});
    endtask
    task automatic wait_frame(input int unsigned n);
        int k = 0;
        while (u_remote.n_frames < n && k < 3000) begin
            @(posedge ref_clk_in);
            k++;
        end
        chk("frame count", 9'(n), 9'(u_remote.n_frames));
    endtask

    task automatic t_reset();
        rd(3'h0, d);
        chk("ctrl1 reset", 9'h000, {1'b0, d & 8'hfd});
        rdc(3'h2, 8'h0b, "status reset");
        chk("pins reset", 9'h0, {7'h0, tx_oe_out, rx_ie_out});
    endtask

    // 8-bit plain, even and odd parity, 9-bit with each ninth bit; expected frame built from the options
    task automatic t_format();
        logic [7:0] cfg [5] = '{8'h80, 8'ha0, 8'hb0, 8'hc1, 8'hc0};
        logic [7:0] dat [5] = '{8'ha5, 8'h35, 8'h35, 8'h3c, 8'hc3};
        logic [8:0] e;
        wr(3'h0, 8'h80);
        wr(3'h1, 8'hc0);
        chk("pins on", 9'h3, {7'h0, tx_oe_out, rx_ie_out});
        for (int i = 0; i < 5; i++) begin
            e = {1'b1, dat[i]};
            if (cfg[i][5]) e[7] = ^dat[i][6:0] ^ cfg[i][4];
            if (cfg[i][6]) e[8] = cfg[i][0];
            wr(3'h0, cfg[i]);
            wr(3'h3, dat[i]);
            wait_frame(u_remote.n_frames + 1);
            chk("tx frame", e, u_remote.last_raw);
        end
    endtask

    // back-to-back characters show the stop length as start spacing
    task automatic t_stop();
        int n;
        for (int s = 0; s < 2; s++) begin
            wr(3'h0, s[0] ? 8'h88 : 8'h80);
            n = u_remote.n_frames;
            wr(3'h3, 8'h55);
            d = 8'h00;
            for (int k = 0; k < 40 && d[0] !== 1'b1; k++) rd(3'h2, d);
            wr(3'h3, 8'h5a);
            wait_frame(n + 2);
            chk("spacing", 9'((10 + s) * 16),
                9'(u_remote.last_start - u_remote.prev_start));
        end
    endtask

    // ninth bit received, interrupt raised, masked and cleared
    task automatic t_rx9();
        int k = 0;
        wr(3'h0, 8'hc0);
        wr(3'h7, 8'h04);
        u_remote.send(9'h15a, 9);
        while (irq_out !== 1'b1 && k < 60) begin
            @(posedge ref_clk_in);
            k++;
        end
        chk("irq set", 9'h1, {8'h0, irq_out});
        rdc(3'h3, 8'h5a, "rx data");
        rd(3'h0, d);
        chk("rx ninth", 9'h1, {8'h0, d[1]});
        wr(3'h7, 8'h00);
        chk("irq masked", 9'h0, {8'h0, irq_out});
        wr(3'h7, 8'h04);
        chk("irq sticky", 9'h1, {8'h0, irq_out});
        wr(3'h6, 8'h04);
        chk("irq clear", 9'h0, {8'h0, irq_out});
        // 8-bit even parity, seven ones sent with a zero parity bit
        wr(3'h0, 8'ha0);
        u_remote.send(9'h07f, 8);
        rdc(3'h2, 8'h8f, "rx parity err");
    endtask

    // disable in mid-character, then status read straight after
    task automatic t_disable();
        int n;
        wr(3'h0, 8'h80);
        wr(3'h3, 8'h77);
        repeat (40) @(posedge ref_clk_in);
        wr(3'h4, 8'h03);
        @(posedge ref_clk_in);
        req_in <= '{addr: 3'h0, wdata: 8'h28, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk_in);
        req_in <= '{addr: 3'h2, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk_in);
        req_in <= '0;
        #1;
        chk("status off", 9'h00b, {1'b0, rdata_out});
        chk("pins off", 9'h0, {7'h0, tx_oe_out, rx_ie_out});
        rdc(3'h1, 8'h00, "ctrl2 off");
        rd(3'h0, d);
        chk("ctrl1 kept", 9'h028, {1'b0, d & 8'hfc});
        rdc(3'h4, 8'h03, "divisor kept");
        wr(3'h4, 8'h00);
        // let the far end finish the cut frame before counting
        repeat (200) @(posedge ref_clk_in);
        n = u_remote.n_frames;
        wr(3'h0, 8'h80);
        wr(3'h1, 8'h80);
        repeat (300) @(posedge ref_clk_in);
        chk("no stale char", 9'(n), 9'(u_remote.n_frames));
    endtask

    task automatic t_break();
        int k = 0;
        wr(3'h0, 8'h84);
        while (tx_o_out !== 1'b0 && k < 100) begin
            @(posedge ref_clk_in);
            k++;
        end
        repeat (13 * 16) @(posedge ref_clk_in);
        chk("break low", 9'h0, {8'h0, tx_o_out});
        wr(3'h0, 8'h80);
        repeat (80) @(posedge ref_clk_in);
        chk("break end", 9'h1, {8'h0, tx_o_out});
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // clock
    initial begin
        ref_clk_in = 1'b0;
        forever #5 ref_clk_in = ~ref_clk_in;
    end

    // main sequence; break runs last since the far end decodes it as frames
    initial begin
        sys_rst_in = 1'b1;
        req_in = '0;
        repeat (3) @(posedge ref_clk_in);
        sys_rst_in <= 1'b0;
        t_reset();
        t_format();
        t_stop();
        t_rx9();
        t_disable();
        t_break();
        summarize();
    end

    // watchdog, well past the roughly 3000 cycles the tests need
    initial begin
        #500000;
        n_mismatch++;
        summarize();
    end
endmodule // uart_frame_control_tb
